//--- design/dwrs_port.sv
// two-wire debug port front end: address register and register selection
module dwrs_port #(
  // arbitrary identification values
  parameter logic [7:0] PART_IDENTIFIER = 8'h5a,
  parameter logic [7:0] SILICON_REVISION = 8'h3c
) (
  // system clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // debug wire
  input wire logic debugClockLine,
  input wire logic debugDataLineIn,
  output logic debugDataLineOut,
  output logic debugDataLineOe,
  // selected external register (flash and crc only)
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrite,
  output logic regRead,
  input wire logic [7:0] regRdData,
  // flash programming
  output logic progEnable,
  output logic flashCmdStrobe,
  output logic [7:0] flashCmd
);

  // link domain state
  dwrs_pkg::dwrs_link_e linkState_reg, linkState_next;
  logic [2:0] bitCnt_reg, bitCnt_next;
  logic [1:0] ins_reg, ins_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] portRegisterSelect_reg, portRegisterSelect_next;
  logic dataOut_reg, dataOut_next, dataOe_reg, dataOe_next;
  logic reqTgl_reg, reqTgl_next, reqWrite_reg, reqWrite_next;
  logic [7:0] reqAddr_reg, reqAddr_next, reqData_reg, reqData_next;
  logic ackS1_reg, ackS2_reg, ackS3_reg, ackSeen;
  logic [7:0] inByte;
  logic [1:0] insNow;

  // system domain state
  dwrs_pkg::dwrs_sys_e sysState_reg, sysState_next;
  logic reqS1_reg, reqS2_reg, reqS3_reg, reqNew;
  logic ackTgl_reg, ackTgl_next;
  logic [7:0] rdData_reg, rdData_next;
  logic [7:0] regAddr_reg, regAddr_next, regWrData_reg, regWrData_next;
  logic regWrite_reg, regWrite_next, regRead_reg, regRead_next;
  logic progEnable_reg, progEnable_next, keyArmed_reg, keyArmed_next;
  logic flashCmdStrobe_reg, flashCmdStrobe_next;
  logic [7:0] flashCmd_reg, flashCmd_next;

  assign inByte = {debugDataLineIn, shift_reg[7:1]};
  assign insNow = {debugDataLineIn, ins_reg[1]};
  assign ackSeen = ackS2_reg ^ ackS3_reg;
  assign reqNew = reqS2_reg ^ reqS3_reg;

  // answer toggle brought onto the wire clock
  always_ff @(posedge debugClockLine or negedge rstn)
  begin
    if (!rstn)
    begin
      ackS1_reg <= 1'b0;
      ackS2_reg <= 1'b0;
      ackS3_reg <= 1'b0;
    end
    else
    begin
      ackS1_reg <= ackTgl_reg;
      ackS2_reg <= ackS1_reg;
      ackS3_reg <= ackS2_reg;
    end
  end

  always_comb
  begin
    linkState_next = linkState_reg;
    bitCnt_next = bitCnt_reg;
    ins_next = ins_reg;
    shift_next = shift_reg;
    portRegisterSelect_next = portRegisterSelect_reg;
    dataOut_next = dataOut_reg;
    dataOe_next = dataOe_reg;
    reqTgl_next = reqTgl_reg;
    reqWrite_next = reqWrite_reg;
    reqAddr_next = reqAddr_reg;
    reqData_next = reqData_reg;
    unique case (linkState_reg)
      dwrs_pkg::L_IDLE:
        if (debugDataLineIn == dwrs_pkg::START_LEVEL)
        begin
          linkState_next = dwrs_pkg::L_INS;
          bitCnt_next = '0;
        end
      dwrs_pkg::L_INS:
      begin
        ins_next = insNow;
        bitCnt_next = bitCnt_reg + 3'h1;
        if (bitCnt_reg == dwrs_pkg::INS_LAST_BIT)
        begin
          bitCnt_next = '0;
          linkState_next = dwrs_pkg::L_DIN;
          if (insNow == dwrs_pkg::INS_ADDR_READ)
          begin
            linkState_next = dwrs_pkg::L_DOUT;
            dataOe_next = 1'b1;
            dataOut_next = portRegisterSelect_reg[0];
            shift_next = {1'b0, portRegisterSelect_reg[7:1]};
          end
          else if (insNow == dwrs_pkg::INS_DATA_READ)
          begin
            linkState_next = dwrs_pkg::L_WAIT;
            reqTgl_next = ~reqTgl_reg;
            reqWrite_next = 1'b0;
            reqAddr_next = portRegisterSelect_reg;
            dataOe_next = 1'b1;
            dataOut_next = 1'b0;
          end
        end
      end
      dwrs_pkg::L_DIN:
      begin
        shift_next = inByte;
        bitCnt_next = bitCnt_reg + 3'h1;
        if (bitCnt_reg == dwrs_pkg::BYTE_LAST_BIT)
        begin
          linkState_next = dwrs_pkg::L_IDLE;
          if (ins_reg == dwrs_pkg::INS_ADDR_WRITE)
            portRegisterSelect_next = inByte;
          else
          begin
            linkState_next = dwrs_pkg::L_WAIT;
            reqTgl_next = ~reqTgl_reg;
            reqWrite_next = 1'b1;
            reqAddr_next = portRegisterSelect_reg;
            reqData_next = inByte;
            dataOe_next = 1'b1;
            dataOut_next = 1'b0;
          end
        end
      end
      dwrs_pkg::L_WAIT:
        if (ackSeen)
        begin
          linkState_next = dwrs_pkg::L_RDY;
          dataOut_next = 1'b1;
          shift_next = rdData_reg;
        end
      dwrs_pkg::L_RDY:
        if (ins_reg == dwrs_pkg::INS_DATA_READ)
        begin
          linkState_next = dwrs_pkg::L_DOUT;
          bitCnt_next = '0;
          dataOut_next = shift_reg[0];
          shift_next = {1'b0, shift_reg[7:1]};
        end
        else
        begin
          linkState_next = dwrs_pkg::L_IDLE;
          dataOe_next = 1'b0;
        end
      dwrs_pkg::L_DOUT:
      begin
        dataOut_next = shift_reg[0];
        shift_next = {1'b0, shift_reg[7:1]};
        bitCnt_next = bitCnt_reg + 3'h1;
        if (bitCnt_reg == dwrs_pkg::BYTE_LAST_BIT)
        begin
          linkState_next = dwrs_pkg::L_IDLE;
          dataOe_next = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge debugClockLine or negedge rstn)
  begin
    if (!rstn)
    begin
      linkState_reg <= dwrs_pkg::L_IDLE;
      bitCnt_reg <= '0;
      ins_reg <= '0;
      shift_reg <= '0;
      portRegisterSelect_reg <= dwrs_pkg::SELECT_RESET;
      dataOut_reg <= 1'b0;
      dataOe_reg <= 1'b0;
      reqTgl_reg <= 1'b0;
      reqWrite_reg <= 1'b0;
      reqAddr_reg <= '0;
      reqData_reg <= '0;
    end
    else
    begin
      linkState_reg <= linkState_next;
      bitCnt_reg <= bitCnt_next;
      ins_reg <= ins_next;
      shift_reg <= shift_next;
      portRegisterSelect_reg <= portRegisterSelect_next;
      dataOut_reg <= dataOut_next;
      dataOe_reg <= dataOe_next;
      reqTgl_reg <= reqTgl_next;
      reqWrite_reg <= reqWrite_next;
      reqAddr_reg <= reqAddr_next;
      reqData_reg <= reqData_next;
    end
  end

  // request toggle brought onto the system clock
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      reqS1_reg <= 1'b0;
      reqS2_reg <= 1'b0;
      reqS3_reg <= 1'b0;
    end
    else
    begin
      reqS1_reg <= reqTgl_reg;
      reqS2_reg <= reqS1_reg;
      reqS3_reg <= reqS2_reg;
    end
  end

  // request word is stable from its toggle until the answer toggle
  always_comb
  begin
    sysState_next = sysState_reg;
    ackTgl_next = ackTgl_reg;
    rdData_next = rdData_reg;
    regAddr_next = regAddr_reg;
    regWrData_next = regWrData_reg;
    regWrite_next = 1'b0;
    regRead_next = 1'b0;
    progEnable_next = progEnable_reg;
    keyArmed_next = keyArmed_reg;
    flashCmdStrobe_next = 1'b0;
    flashCmd_next = flashCmd_reg;
    unique case (sysState_reg)
      dwrs_pkg::S_IDLE:
        if (reqNew && reqWrite_reg)
        begin
          ackTgl_next = ~ackTgl_reg;
          // only mapped writable targets see a write
          if (dwrs_pkg::dwrs_is_external(reqAddr_reg))
          begin
            regWrite_next = 1'b1;
            regAddr_next = reqAddr_reg;
            regWrData_next = reqData_reg;
          end
          if (reqAddr_reg == dwrs_pkg::ADDR_FLASH_CTL)
          begin
            keyArmed_next = reqData_reg == dwrs_pkg::PROG_KEY_FIRST;
            if (keyArmed_reg && reqData_reg == dwrs_pkg::PROG_KEY_SECOND)
              progEnable_next = 1'b1;
          end
          if (reqAddr_reg == dwrs_pkg::ADDR_FLASH_DATA && progEnable_reg &&
              dwrs_pkg::dwrs_is_flash_cmd(reqData_reg))
          begin
            flashCmdStrobe_next = 1'b1;
            flashCmd_next = reqData_reg;
          end
        end
        else if (reqNew)
        begin
          ackTgl_next = ~ackTgl_reg;
          rdData_next = dwrs_pkg::UNMAPPED_READ;
          if (reqAddr_reg == dwrs_pkg::ADDR_PART_ID)
            rdData_next = PART_IDENTIFIER;
          else if (reqAddr_reg == dwrs_pkg::ADDR_REVISION)
            rdData_next = SILICON_REVISION;
          else if (dwrs_pkg::dwrs_is_external(reqAddr_reg))
          begin
            ackTgl_next = ackTgl_reg;
            regRead_next = 1'b1;
            regAddr_next = reqAddr_reg;
            sysState_next = dwrs_pkg::S_READ;
          end
        end
      dwrs_pkg::S_READ:
      begin
        rdData_next = regRdData;
        ackTgl_next = ~ackTgl_reg;
        sysState_next = dwrs_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sysState_reg <= dwrs_pkg::S_IDLE;
      ackTgl_reg <= 1'b0;
      rdData_reg <= '0;
      regAddr_reg <= '0;
      regWrData_reg <= '0;
      regWrite_reg <= 1'b0;
      regRead_reg <= 1'b0;
      progEnable_reg <= 1'b0;
      keyArmed_reg <= 1'b0;
      flashCmdStrobe_reg <= 1'b0;
      flashCmd_reg <= '0;
    end
    else
    begin
      sysState_reg <= sysState_next;
      ackTgl_reg <= ackTgl_next;
      rdData_reg <= rdData_next;
      regAddr_reg <= regAddr_next;
      regWrData_reg <= regWrData_next;
      regWrite_reg <= regWrite_next;
      regRead_reg <= regRead_next;
      progEnable_reg <= progEnable_next;
      keyArmed_reg <= keyArmed_next;
      flashCmdStrobe_reg <= flashCmdStrobe_next;
      flashCmd_reg <= flashCmd_next;
    end
  end

  assign debugDataLineOut = dataOut_reg;
  assign debugDataLineOe = dataOe_reg;
  assign regAddr = regAddr_reg;
  assign regWrData = regWrData_reg;
  assign regWrite = regWrite_reg;
  assign regRead = regRead_reg;
  assign progEnable = progEnable_reg;
  assign flashCmdStrobe = flashCmdStrobe_reg;
  assign flashCmd = flashCmd_reg;

  a_line_idle_free: assert property (
    @(posedge debugClockLine) disable iff (!rstn)
    linkState_reg == dwrs_pkg::L_IDLE |-> !dataOe_reg)
    else $error("data line driven while idle");
  a_select_written: assert property (
    @(posedge debugClockLine) disable iff (!rstn)
    linkState_reg == dwrs_pkg::L_DIN && ins_reg == dwrs_pkg::INS_ADDR_WRITE
    && bitCnt_reg == dwrs_pkg::BYTE_LAST_BIT
    |=> portRegisterSelect_reg == $past(inByte))
    else $error("address register missed its write");
  a_part_id_read: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    reqNew && !reqWrite_reg && reqAddr_reg == dwrs_pkg::ADDR_PART_ID
    |=> rdData_reg == PART_IDENTIFIER && !regRead_reg)
    else $error("part id read wrong");
  a_revision_read: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    reqNew && !reqWrite_reg && reqAddr_reg == dwrs_pkg::ADDR_REVISION
    |=> rdData_reg == SILICON_REVISION)
    else $error("revision read wrong");
  a_id_write_dropped: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    reqNew && !dwrs_pkg::dwrs_is_external(reqAddr_reg)
    |=> !regWrite_reg && !regRead_reg)
    else $error("unmapped or id access reached a register");
  a_flash_write_routed: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    reqNew && reqWrite_reg && (reqAddr_reg == dwrs_pkg::ADDR_FLASH_CTL ||
    reqAddr_reg == dwrs_pkg::ADDR_FLASH_DATA)
    |=> regWrite_reg && regAddr_reg == $past(reqAddr_reg))
    else $error("flash register write not routed");
  a_crc_select_routed: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    reqNew && dwrs_pkg::dwrs_is_crc(reqAddr_reg)
    |=> (regWrite_reg || regRead_reg) && regAddr_reg == $past(reqAddr_reg))
    else $error("crc register access not routed");
  a_read_captured: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    regRead_reg |=> rdData_reg == $past(regRdData) &&
    ackTgl_reg != $past(ackTgl_reg))
    else $error("external read not returned");
  a_command_gated: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    flashCmdStrobe_reg |-> progEnable_reg &&
    dwrs_pkg::dwrs_is_flash_cmd(flashCmd_reg) && $past(reqNew))
    else $error("flash command outside programming mode");

endmodule

//--- inc/dwrs_pkg.sv
// constants, types and decode helpers for the debug wire register select port
package dwrs_pkg;

  localparam int DATA_W = 8;

  // selection map of the address register
  localparam logic [7:0] ADDR_PART_ID = 8'h00;
  localparam logic [7:0] ADDR_REVISION = 8'h01;
  localparam logic [7:0] ADDR_FLASH_CTL = 8'h02;
  localparam logic [7:0] ADDR_FLASH_DATA = 8'hbf;
  localparam logic [7:0] ADDR_CRC_AUTO = 8'hd2;
  localparam logic [7:0] ADDR_CRC_COUNT = 8'hd3;
  localparam logic [7:0] ADDR_CRC_CTRL = 8'hce;
  localparam logic [7:0] ADDR_CRC_RESULT = 8'hde;
  localparam logic [7:0] ADDR_CRC_REVERSE = 8'hcf;
  localparam logic [7:0] ADDR_CRC_INPUT = 8'hdd;

  localparam logic [7:0] SELECT_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // programming unlock keys and flash commands
  localparam logic [7:0] PROG_KEY_FIRST = 8'h02;
  localparam logic [7:0] PROG_KEY_SECOND = 8'h01;
  localparam logic [7:0] CMD_BLOCK_READ = 8'h06;
  localparam logic [7:0] CMD_BLOCK_WRITE = 8'h07;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h08;
  localparam logic [7:0] CMD_DEVICE_ERASE = 8'h03;

  // wire framing
  localparam logic START_LEVEL = 1'b0;
  localparam logic [1:0] INS_DATA_READ = 2'h0;
  localparam logic [1:0] INS_DATA_WRITE = 2'h1;
  localparam logic [1:0] INS_ADDR_READ = 2'h2;
  localparam logic [1:0] INS_ADDR_WRITE = 2'h3;
  localparam logic [2:0] INS_LAST_BIT = 3'h1;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

  typedef enum logic [2:0] {L_IDLE, L_INS, L_DIN, L_WAIT, L_RDY, L_DOUT}
    dwrs_link_e;
  typedef enum logic {S_IDLE, S_READ} dwrs_sys_e;

  function automatic logic dwrs_is_crc(input logic [7:0] a);
    return a == ADDR_CRC_AUTO || a == ADDR_CRC_COUNT ||
           a == ADDR_CRC_CTRL || a == ADDR_CRC_RESULT ||
           a == ADDR_CRC_REVERSE || a == ADDR_CRC_INPUT;
  endfunction

  function automatic logic dwrs_is_external(input logic [7:0] a);
    return a == ADDR_FLASH_CTL || a == ADDR_FLASH_DATA || dwrs_is_crc(a);
  endfunction

  function automatic logic dwrs_is_flash_cmd(input logic [7:0] v);
    return v == CMD_BLOCK_READ || v == CMD_BLOCK_WRITE ||
           v == CMD_PAGE_ERASE || v == CMD_DEVICE_ERASE;
  endfunction

endpackage

//--- testbench/dwrs_adapter.sv
// adapter model: drives the wire clock and shares the data line
module dwrs_adapter (
  // wire side
  output logic debugClockLine,
  output logic adOe,
  output logic adOut,
  input wire logic line
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    debugClockLine = 1'b0;
    adOe = 1'b0;
    adOut = 1'b1;
  end

  task automatic pulse(output logic smp);
    #62.5 debugClockLine = 1'b1;
    #62.5 debugClockLine = 1'b0;
    smp = line;
  endtask

  task automatic send(input logic b, output logic smp);
    adOe = 1'b1;
    adOut = b;
    pulse(smp);
  endtask

  // line released while clocking, used around reset
  task automatic idle(input int n);
    logic s;
    adOe = 1'b0;
    repeat (n) pulse(s);
  endtask

  task automatic xfer(input logic [1:0] ins, input logic [7:0] wd,
                      output logic [7:0] rd);
    logic s;
    int n;
    rd = 8'h00;
    n = 0;
    send(1'b0, s);
    send(ins[0], s);
    send(ins[1], s);
    if (ins[0])
      for (int i = 0; i < 8; i++) send(wd[i], s);
    adOe = 1'b0;
    adOut = 1'b1;
    if (ins != 2'h3)
    begin
      if (ins != 2'h2)
      begin
        while (s !== 1'b1 && n < 20)
        begin
          pulse(s);
          n++;
        end
        pulse(s);
      end
      if (!ins[0])
        for (int i = 0; i < 8; i++)
        begin
          rd[i] = s;
          pulse(s);
        end
    end
    // gap so the next frame never reassigns the line in this time step
    #62.5;
  endtask
endmodule

//--- testbench/dwrs_port_test.sv
// self-checking bench for the debug wire register select port
module dwrs_port_test;
  timeunit 1ns;
  timeprecision 100ps;
  // arbitrary identification values
  localparam logic [7:0] PART_ID = 8'h96;
  localparam logic [7:0] REV_ID = 8'h4b;
  logic sys_clk, rstn, dutOut, dutOe, adOe, adOut, line, linkClk;
  logic regWrite, regRead, progEnable, flashCmdStrobe;
  logic [7:0] regAddr, regWrData, regRdData, flashCmd, rd;
  logic [7:0] lastWrAddr, lastWrData;
  logic [7:0] ext [256];
  int failures, samplesChecked, wrCount, rdCount, cmdCount, cycles;

  // pulled-up data line
  assign line = dutOe ? dutOut : (adOe ? adOut : 1'b1);

  dwrs_port #(.PART_IDENTIFIER(PART_ID), .SILICON_REVISION(REV_ID)) i_dut (
    .sys_clk(sys_clk), .rstn(rstn), .debugClockLine(linkClk),
    .debugDataLineIn(line), .debugDataLineOut(dutOut),
    .debugDataLineOe(dutOe), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .progEnable(progEnable), .flashCmdStrobe(flashCmdStrobe),
    .flashCmd(flashCmd)
  );

  dwrs_adapter i_ad (
    .debugClockLine(linkClk), .adOe(adOe), .adOut(adOut), .line(line)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // flash and crc registers outside the block
  always @(posedge sys_clk)
  begin
    if (regWrite)
    begin
      ext[regAddr] <= regWrData;
      lastWrAddr <= regAddr;
      lastWrData <= regWrData;
      wrCount++;
    end
    if (regRead) rdCount++;
    if (flashCmdStrobe) cmdCount++;
    cycles++;
    if (cycles > 10000)
    begin
      failures++;
      final_report();
    end
  end

  always @(negedge sys_clk) regRdData <= ext[regAddr];

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d failures=%0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic do_reset();
    @(negedge sys_clk);
    rstn = 1'b0;
    i_ad.idle(2);
    repeat (5) @(negedge sys_clk);
    rstn = 1'b1;
  endtask

  task automatic sel(input logic [7:0] a);
    i_ad.xfer(2'h3, a, rd);
  endtask

  task automatic dwr(input logic [7:0] a, input logic [7:0] v);
    sel(a);
    i_ad.xfer(2'h1, v, rd);
  endtask

  task automatic drd(input logic [7:0] a);
    sel(a);
    i_ad.xfer(2'h0, 8'h00, rd);
  endtask

  task automatic t_reset_state();
    i_ad.xfer(2'h2, 8'h00, rd);
    chk(rd, 8'h00);
    chk({7'h0, dutOe}, 8'h00);
    $display("t_reset_state done");
  endtask

  task automatic t_addr();
    logic [7:0] vals [3] = '{8'ha5, 8'hff, 8'h5a};
    foreach (vals[i])
    begin
      sel(vals[i]);
      i_ad.xfer(2'h2, 8'h00, rd);
      chk(rd, vals[i]);
    end
    $display("t_addr done");
  endtask

  task automatic t_ids();
    int n;
    n = wrCount;
    drd(dwrs_pkg::ADDR_PART_ID);
    chk(rd, PART_ID);
    drd(dwrs_pkg::ADDR_REVISION);
    chk(rd, REV_ID);
    dwr(dwrs_pkg::ADDR_PART_ID, 8'h11);
    dwr(dwrs_pkg::ADDR_REVISION, 8'h22);
    chk(8'(wrCount - n), 8'h00);
    drd(dwrs_pkg::ADDR_PART_ID);
    chk(rd, PART_ID);
    $display("t_ids done");
  endtask

  task automatic t_map();
    logic [7:0] map [8] = '{dwrs_pkg::ADDR_FLASH_CTL,
      dwrs_pkg::ADDR_FLASH_DATA, dwrs_pkg::ADDR_CRC_AUTO,
      dwrs_pkg::ADDR_CRC_COUNT, dwrs_pkg::ADDR_CRC_CTRL,
      dwrs_pkg::ADDR_CRC_RESULT, dwrs_pkg::ADDR_CRC_REVERSE,
      dwrs_pkg::ADDR_CRC_INPUT};
    int n;
    foreach (map[i])
    begin
      n = rdCount;
      dwr(map[i], map[i] ^ 8'h5a);
      chk(lastWrAddr, map[i]);
      chk(lastWrData, map[i] ^ 8'h5a);
      drd(map[i]);
      chk(rd, map[i] ^ 8'h5a);
      chk(8'(rdCount - n), 8'h01);
    end
    $display("t_map done");
  endtask

  task automatic t_unmapped();
    logic [7:0] adr [2] = '{8'h03, 8'hbe};
    int n;
    foreach (adr[i])
    begin
      n = wrCount + rdCount;
      dwr(adr[i], 8'h77);
      drd(adr[i]);
      chk(rd, dwrs_pkg::UNMAPPED_READ);
      chk(8'(wrCount + rdCount - n), 8'h00);
    end
    $display("t_unmapped done");
  endtask

  task automatic t_unlock();
    logic [7:0] cmds [4] = '{dwrs_pkg::CMD_BLOCK_READ,
      dwrs_pkg::CMD_BLOCK_WRITE, dwrs_pkg::CMD_PAGE_ERASE,
      dwrs_pkg::CMD_DEVICE_ERASE};
    int c;
    c = cmdCount;
    dwr(dwrs_pkg::ADDR_FLASH_DATA, dwrs_pkg::CMD_BLOCK_READ);
    chk(8'(cmdCount - c), 8'h00);
    dwr(dwrs_pkg::ADDR_FLASH_CTL, dwrs_pkg::PROG_KEY_SECOND);
    dwr(dwrs_pkg::ADDR_FLASH_CTL, dwrs_pkg::PROG_KEY_FIRST);
    chk({7'h0, progEnable}, 8'h00);
    dwr(dwrs_pkg::ADDR_FLASH_CTL, dwrs_pkg::PROG_KEY_SECOND);
    chk({7'h0, progEnable}, 8'h01);
    foreach (cmds[i])
    begin
      dwr(dwrs_pkg::ADDR_FLASH_DATA, cmds[i]);
      chk(8'(cmdCount - c), 8'(i + 1));
      chk(flashCmd, cmds[i]);
    end
    dwr(dwrs_pkg::ADDR_FLASH_DATA, 8'h05);
    chk(8'(cmdCount - c), 8'h04);
    $display("t_unlock done");
  endtask

  task automatic t_reset_again();
    do_reset();
    chk({7'h0, progEnable}, 8'h00);
    i_ad.xfer(2'h2, 8'h00, rd);
    chk(rd, dwrs_pkg::SELECT_RESET);
    $display("t_reset_again done");
  endtask

  initial
  begin
    rstn = 1'b0;
    regRdData = 8'h00;
    failures = 0;
    samplesChecked = 0;
    wrCount = 0;
    rdCount = 0;
    cmdCount = 0;
    cycles = 0;
    do_reset();
    t_reset_state();
    t_addr();
    t_ids();
    t_map();
    t_unmapped();
    t_unlock();
    t_reset_again();
    final_report();
  end
endmodule
